/* core/seal_ctrl_map.svh */
// register map, field positions, reset values and timing constants
`ifndef SEAL_CTRL_MAP_SVH
`define SEAL_CTRL_MAP_SVH
`define REG_CTRL 4'h0
`define REG_SETPT 4'h1
`define REG_ACTUAL 4'h2
`define REG_FAULT 4'h3
`define REG_STATUS 4'h4
`define REG_CALCNT 4'h5
`define REG_LINE 4'h6
`define CTRL_MEASURE_BIT 0
`define CTRL_RESULT_OK_BIT 1
`define CTRL_RESULT_ERR_BIT 2
`define SETPT_RESET 9'h0C8
`define SETPT_MAX 9'h12C
`define SETPT_MIN_HEAT 9'h028
`define CAL_TEMP 9'h014
`define CAL_START 4'hD
`define POWERUP_MS 2000
`define KEY_HOLD_MS 2000
`define CAL_STEP_MS 1000
`define FLASH_MS 500
`define FREQ_MIN_HZ 47
`define FREQ_MAX_HZ 63
`define CLK_HZ 25000000
// err bits: 0=101..103 1=104..106 2=107/108 3=201..203 4=211
//           5=304 6=308 7=801 8=9xx
`define ERR_MEAS 0
`define ERR_CFG 1
`define ERR_STEP 2
`define ERR_FREQ 3
`define ERR_DATA 4
`define ERR_RISE 5
`define ERR_WIN 6
`define ERR_INT 7
`define ERR_DEV 8
`define ERR_W 9
`define BLOCK_FIRST 9'h189
`define BLOCK_LATER 9'h1E8
`endif

/* core/seal_ctrl_pkg.sv */
// types shared by the supervisory control block
package seal_ctrl_pkg;
  typedef enum logic [2:0] {
    DISP_POWERUP,
    DISP_HOME,
    DISP_SETTING,
    DISP_ALARM,
    DISP_CAL_COUNT,
    DISP_CAL_STARS
  } disp_mode_t;
  typedef enum logic [1:0] {
    MODE_POWERUP,
    MODE_RUN,
    MODE_CAL
  } mode_t;
endpackage : seal_ctrl_pkg

/* core/tick_if.sv */
// millisecond tick carried from the timebase to the controller
`timescale 1ns/1ps
interface tick_if;
  logic ms_tick;
  modport src (output ms_tick);
  modport dst (input ms_tick);
endinterface : tick_if

/* core/ms_timebase.sv */
// millisecond tick divider
`timescale 1ns/1ps
`include "seal_ctrl_map.svh"
module ms_timebase #(
  parameter int CLK_HZ = `CLK_HZ
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  tick_if.src tick
);
  localparam int DIV = CLK_HZ / 1000;
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } tb_state_t;
  tb_state_t st_ff;
  tb_state_t nxt_st;
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.cnt == 16'(DIV - 1)) begin
      nxt_st.cnt = 16'h0000;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 16'h0001;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end
  assign tick.ms_tick = st_ff.tick & ce_i;
endmodule : ms_timebase

/* core/seal_ctrl.sv */
// heatsealing supervisory control: display, set point, zero calibration
//
// Behaviour
// - line frequency 47..63 Hz accepted automatically
// - power-up message about two seconds
// - successful calibration reports 20 degrees
// - failed calibration raises configuration error alarm
// - home display shows set and actual
// - faults shown as alarm immediately, except during the power-up message
// - up/down keys change set point immediately
// - set point clamped to 300 degrees
// - no heating if set point not above 40
// - calibration needs key held over two seconds
// - calibration run ten to fifteen seconds, unheated
// - display countdown 13 to 0 during calibration
// - fast cooling refuses calibration, flashing stars
// - calibration ignored while start asserted
// - before first good operation, early error set blocks
// - after good operation, later error set blocks
// - start enables regulation until released
// - start ignored during calibration run
//
// The implementer's own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "seal_ctrl_map.svh"
module seal_ctrl
  import seal_ctrl_pkg::*;
#(
  parameter int CLK_HZ = `CLK_HZ,
  parameter int POWERUP_MS = `POWERUP_MS,
  parameter int KEY_HOLD_MS = `KEY_HOLD_MS,
  parameter int CAL_STEP_MS = `CAL_STEP_MS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // classic wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [5:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // front panel and machine
  input wire logic key_up_i,
  input wire logic key_down_i,
  input wire logic key_cal_i,
  input wire logic start_i,
  input wire logic cooling_fast_i,
  input wire logic [`ERR_W-1:0] fault_i,
  input wire logic [8:0] actual_temp_i,
  output logic heat_en_o,
  output logic cal_measure_o,
  output seal_ctrl_pkg::disp_mode_t disp_mode_o,
  output logic [3:0] disp_count_o,
  output logic [8:0] disp_actual_o,
  output logic [8:0] disp_set_o,
  output logic [`ERR_W-1:0] disp_err_o
);
  import seal_ctrl_pkg::*;

  // ==========================================================
  // timing
  localparam int HOLD_T = KEY_HOLD_MS;
  localparam int PWR_T = POWERUP_MS;
  localparam int STEP_T = CAL_STEP_MS;
  localparam int FLASH_T = `FLASH_MS;

  tick_if tk ();
  ms_timebase #(.CLK_HZ(CLK_HZ)) u_tb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .tick(tk)
  );

  // ==========================================================
  // state
  typedef struct packed {
    mode_t mode;
    logic [8:0] setpt;
    logic [8:0] actual;
    logic [8:0] zero_ofs;
    logic [15:0] ms_cnt;
    logic [15:0] hold_cnt;
    logic hold_done;
    logic [3:0] cal_cnt;
    logic stars;
    logic [15:0] flash_cnt;
    logic flash;
    logic good_op;
    logic cal_fail;
    logic measure;
    logic up_q;
    logic down_q;
    logic ack;
    logic [31:0] rdata;
    logic [15:0] line_hz;
  } st_t;
  st_t st_ff;
  st_t nxt_st;

  logic [`ERR_W-1:0] faults;
  logic cal_block;
  logic wb_req;
  logic wb_wr;
  logic res_ok;
  logic res_err;
  logic freq_ok;

  always_comb begin
    faults = fault_i;
    faults[`ERR_CFG] = fault_i[`ERR_CFG] | st_ff.cal_fail;
    // error class gating switches after first good operation
    if (st_ff.good_op) begin
      cal_block = |(faults & `BLOCK_LATER);
    end else begin
      cal_block = |(faults & `BLOCK_FIRST);
    end
    wb_req = cyc_i & stb_i & ~st_ff.ack;
    wb_wr = wb_req & we_i;
    res_ok = wb_wr & (adr_i[5:2] == `REG_CTRL) & sel_i[0]
      & dat_i[`CTRL_RESULT_OK_BIT];
    res_err = wb_wr & (adr_i[5:2] == `REG_CTRL) & sel_i[0]
      & dat_i[`CTRL_RESULT_ERR_BIT];
    // frequency is measured outside and written in; just range check
    freq_ok = (st_ff.line_hz >= 16'(`FREQ_MIN_HZ))
      & (st_ff.line_hz <= 16'(`FREQ_MAX_HZ));
  end

  // ==========================================================
  // next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.up_q = key_up_i;
    nxt_st.down_q = key_down_i;
    nxt_st.ack = wb_req;
    // trimmed reading; wraps if the band reads below its zero point
    nxt_st.actual = actual_temp_i + st_ff.zero_ofs;

    // flashing phase for the refusal stars
    if (tk.ms_tick) begin
      if (st_ff.flash_cnt == 16'(FLASH_T - 1)) begin
        nxt_st.flash_cnt = 16'h0000;
        nxt_st.flash = ~st_ff.flash;
      end else begin
        nxt_st.flash_cnt = st_ff.flash_cnt + 16'h0001;
      end
    end

    // set point keys act on press edge, in any mode
    if (key_up_i & ~st_ff.up_q) begin
      if (st_ff.setpt < `SETPT_MAX) begin
        nxt_st.setpt = st_ff.setpt + 9'h001;
      end
    end else if (key_down_i & ~st_ff.down_q) begin
      if (st_ff.setpt != 9'h000) begin
        nxt_st.setpt = st_ff.setpt - 9'h001;
      end
    end
    if (wb_wr & (adr_i[5:2] == `REG_SETPT) & sel_i[0]) begin
      nxt_st.setpt = (dat_i[8:0] > `SETPT_MAX) ? `SETPT_MAX
        : dat_i[8:0];
    end
    if (wb_wr & (adr_i[5:2] == `REG_LINE) & (&sel_i[1:0])) begin
      nxt_st.line_hz = dat_i[15:0];
    end

    // hold timer, restarted on any release
    if (!key_cal_i) begin
      nxt_st.hold_cnt = 16'h0000;
      nxt_st.hold_done = 1'b0;
      nxt_st.stars = 1'b0;
    end else if (tk.ms_tick & ~st_ff.hold_done) begin
      if (st_ff.hold_cnt == 16'(HOLD_T)) begin
        nxt_st.hold_done = 1'b1;
      end else begin
        nxt_st.hold_cnt = st_ff.hold_cnt + 16'h0001;
      end
    end

    unique case (st_ff.mode)
      MODE_POWERUP: begin
        if (tk.ms_tick) begin
          if (st_ff.ms_cnt == 16'(PWR_T - 1)) begin
            nxt_st.mode = MODE_RUN;
            nxt_st.ms_cnt = 16'h0000;
          end else begin
            nxt_st.ms_cnt = st_ff.ms_cnt + 16'h0001;
          end
        end
      end
      MODE_RUN: begin
        if (start_i & ~(|faults) & freq_ok) begin
          nxt_st.good_op = 1'b1;
        end
        // request fires once, as the hold passes the threshold
        if (key_cal_i & tk.ms_tick & ~st_ff.hold_done
            & (st_ff.hold_cnt == 16'(HOLD_T))) begin
          if (start_i) begin
            nxt_st.stars = 1'b0;
          end else if (cooling_fast_i) begin
            nxt_st.stars = 1'b1;
          end else if (!cal_block) begin
            nxt_st.mode = MODE_CAL;
            nxt_st.cal_cnt = `CAL_START;
            nxt_st.ms_cnt = 16'h0000;
            nxt_st.measure = 1'b1;
            nxt_st.cal_fail = 1'b0;
          end
        end
      end
      MODE_CAL: begin
        // about 13 s of countdown, no heating meanwhile
        if (tk.ms_tick) begin
          if (st_ff.ms_cnt == 16'(STEP_T - 1)) begin
            nxt_st.ms_cnt = 16'h0000;
            if (st_ff.cal_cnt != 4'h0) begin
              nxt_st.cal_cnt = st_ff.cal_cnt - 4'h1;
            end
          end else begin
            nxt_st.ms_cnt = st_ff.ms_cnt + 16'h0001;
          end
        end
        // measuring path reports its result at or after count zero
        if (st_ff.cal_cnt == 4'h0) begin
          if (res_err) begin
            nxt_st.cal_fail = 1'b1;
            nxt_st.mode = MODE_RUN;
            nxt_st.measure = 1'b0;
          end else if (res_ok) begin
            nxt_st.mode = MODE_RUN;
            nxt_st.measure = 1'b0;
          end
        end
      end
      default: nxt_st.mode = MODE_POWERUP;
    endcase
    // zero point reading forced to calibration temperature
    if (st_ff.mode == MODE_CAL && st_ff.cal_cnt == 4'h0 && res_ok) begin
      nxt_st.actual = `CAL_TEMP;
      nxt_st.zero_ofs = `CAL_TEMP - actual_temp_i;
    end

    // register read data
    nxt_st.rdata = 32'h0000_0000;
    unique case (adr_i[5:2])
      `REG_CTRL: nxt_st.rdata = {31'h0000_0000, st_ff.measure};
      `REG_SETPT: nxt_st.rdata = {23'h00_0000, st_ff.setpt};
      `REG_ACTUAL: nxt_st.rdata = {23'h00_0000, st_ff.actual};
      `REG_FAULT: nxt_st.rdata = {23'h00_0000, faults};
      `REG_STATUS: nxt_st.rdata = {25'h000_0000, st_ff.stars,
        st_ff.good_op, heat_en_o, st_ff.hold_done, st_ff.mode,
        freq_ok};
      `REG_CALCNT: nxt_st.rdata = {28'h000_0000, st_ff.cal_cnt};
      `REG_LINE: nxt_st.rdata = {16'h0000, st_ff.line_hz};
      default: nxt_st.rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.mode <= MODE_POWERUP;
      st_ff.setpt <= `SETPT_RESET;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // outputs
  always_comb begin
    // start ignored while calibrating; needs set point above minimum
    heat_en_o = (st_ff.mode == MODE_RUN) & start_i
      & (st_ff.setpt > `SETPT_MIN_HEAT)
      & ~(|faults) & freq_ok;
    cal_measure_o = st_ff.measure;
    // alarm outranks everything except the power-up message
    if (st_ff.mode == MODE_POWERUP) begin
      disp_mode_o = DISP_POWERUP;
    end else if (|faults) begin
      disp_mode_o = DISP_ALARM;
    end else if (st_ff.mode == MODE_CAL) begin
      disp_mode_o = DISP_CAL_COUNT;
    end else if (st_ff.stars & st_ff.flash) begin
      disp_mode_o = DISP_CAL_STARS;
    end else if (key_up_i | key_down_i) begin
      disp_mode_o = DISP_SETTING;
    end else begin
      disp_mode_o = DISP_HOME;
    end
  end

  assign disp_count_o = st_ff.cal_cnt;
  assign disp_actual_o = st_ff.actual;
  assign disp_set_o = st_ff.setpt;
  assign disp_err_o = faults;
  assign dat_o = st_ff.rdata;
  assign ack_o = st_ff.ack;
endmodule : seal_ctrl

/* verification/seal_ctrl_assertions.sv */
// concurrent checks on the supervisory control ports
`timescale 1ns/1ps
module seal_ctrl_chk #(
  parameter int CLK_HZ = 25000000,
  parameter int KEY_HOLD_MS = 2000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic key_cal_i,
  input wire logic heat_en_o,
  input wire logic cal_measure_o,
  input wire seal_ctrl_pkg::disp_mode_t disp_mode_o,
  input wire logic [3:0] disp_count_o,
  input wire logic [8:0] disp_set_o
);
  import seal_ctrl_pkg::*;
  // tick phase is unknown at press, so one ms of slack
  localparam int HOLD_MIN = (KEY_HOLD_MS - 1) * (CLK_HZ / 1000);
  // wide enough for a full hold at the real clock rate
  logic [31:0] key_cnt_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i || !key_cal_i) begin
      key_cnt_ff <= 32'h0000_0000;
    end else if (key_cnt_ff != 32'hFFFF_FFFF) begin
      key_cnt_ff <= key_cnt_ff + 32'h0000_0001;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // properties
  property p_set_max; disp_set_o <= 9'h12C; endproperty
  property p_heat_min; heat_en_o |-> disp_set_o > 9'h028; endproperty
  property p_heat_start; heat_en_o |-> start_i; endproperty
  property p_cal_cold; cal_measure_o |-> !heat_en_o; endproperty
  property p_cal_load; $rose(cal_measure_o) |-> disp_count_o == 4'hD;
  endproperty
  property p_cal_step;
    cal_measure_o && $past(cal_measure_o) && $changed(disp_count_o)
      |-> disp_count_o == $past(disp_count_o) - 4'h1;
  endproperty
  property p_cal_idle; $rose(cal_measure_o) |-> !$past(start_i); endproperty
  property p_cal_hold; $rose(cal_measure_o) |-> key_cnt_ff >= HOLD_MIN;
  endproperty
  a_set_max: assert property (p_set_max)
    else $error("set point above limit");
  a_heat_min: assert property (p_heat_min)
    else $error("heating with low set point");
  a_heat_start: assert property (p_heat_start)
    else $error("heating without start");
  a_cal_cold: assert property (p_cal_cold)
    else $error("heating during calibration");
  a_cal_load: assert property (p_cal_load)
    else $error("countdown not loaded with 13");
  a_cal_step: assert property (p_cal_step)
    else $error("countdown step wrong");
  a_cal_idle: assert property (p_cal_idle)
    else $error("calibration began with start high");
  a_cal_hold: assert property (p_cal_hold)
    else $error("calibration began on short hold");
  c_cal: cover property ($rose(cal_measure_o));
  c_stars: cover property (disp_mode_o == DISP_CAL_STARS);
  c_heat: cover property (heat_en_o);
endmodule : seal_ctrl_chk

/* verification/band_model.sv */
// machine start merge and heating band temperature
`timescale 1ns/1ps
module band_model (
  input wire logic clk_i,
  input wire logic heat_en_i,
  input wire logic start_24v_i,
  input wire logic start_contact_i,
  output logic start_o,
  output logic [8:0] temp_o
);
  assign start_o = start_24v_i | start_contact_i;
  // ambient sits above the zero point so a calibration shift shows
  initial temp_o = 9'h019;
  // band warms under power and creeps back to ambient
  always @(posedge clk_i) begin
    if (heat_en_i && temp_o < 9'h0FA) temp_o <= temp_o + 9'h001;
    else if (!heat_en_i && temp_o > 9'h019) temp_o <= temp_o - 9'h001;
  end
endmodule : band_model

/* verification/heatseal_calibration_start_control_bench.sv */
// self-checking bench for the supervisory control block
`timescale 1ns/1ps
module heatseal_calibration_start_control_bench;
  import seal_ctrl_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, ack;
  logic kup = 1'b0, kdn = 1'b0, kcal = 1'b0, s24 = 1'b0, scon = 1'b0;
  logic cool = 1'b0, start, heat, meas;
  logic ce = 1'b1;
  logic [3:0] sel = 4'hF;
  logic [5:0] adr = 6'h00;
  logic [31:0] dat_w = 32'h0, dat_r, rd;
  logic [8:0] fault = 9'h000, temp, act, setp, err;
  logic [3:0] cnt;
  disp_mode_t mode;
  int failures = 0, samples_checked = 0;
  localparam logic [8:0] TIN [4] = '{9'h064, 9'h12C, 9'h12D, 9'h1FF};
  localparam logic [8:0] TEX [4] = '{9'h064, 9'h12C, 9'h12C, 9'h12C};
  localparam logic [31:0] LIN [5] = '{32'h2E, 32'h2F, 32'h3F, 32'h40, 32'h32};
  localparam logic LHE [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  always #20 clk_i = ~clk_i;
  seal_ctrl #(.CLK_HZ(10000), .POWERUP_MS(5), .KEY_HOLD_MS(5),
    .CAL_STEP_MS(3)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .cyc_i(cyc), .stb_i(cyc), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .key_up_i(kup),
    .key_down_i(kdn), .key_cal_i(kcal), .start_i(start),
    .cooling_fast_i(cool), .fault_i(fault), .actual_temp_i(temp),
    .heat_en_o(heat), .cal_measure_o(meas), .disp_mode_o(mode),
    .disp_count_o(cnt), .disp_actual_o(act), .disp_set_o(setp),
    .disp_err_o(err));
  band_model band_u (.clk_i(clk_i), .heat_en_i(heat), .start_24v_i(s24),
    .start_contact_i(scon), .start_o(start), .temp_o(temp));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dat_r;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic hold(input int n);
    kcal <= 1'b1;
    repeat (n) @(posedge clk_i);
    kcal <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : hold
  task automatic tap(input logic up);
    kup <= up;
    kdn <= !up;
    repeat (2) @(posedge clk_i);
    kup <= 1'b0;
    kdn <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : tap
  task automatic conclude;
    if (failures == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  // run needs about 12000 cycles, mostly the slow star blink
  initial begin
    repeat (40000) @(posedge clk_i);
    failures++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    chk(setp, 9'h0C8);
    rst_i <= 1'b0;
    repeat (30) @(posedge clk_i);
    chk(mode, DISP_POWERUP);
    repeat (40) @(posedge clk_i);
    chk(mode, DISP_HOME);
    wb(1'b1, 6'h18, 32'h32);
    wb(1'b0, 6'h3C, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 6'h04, TIN[i]);
      wb(1'b0, 6'h04, 32'h0);
      chk(rd, TEX[i]);
      chk(setp, TEX[i]);
    end
    tap(1'b1);
    chk(setp, 9'h12C);
    kup <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(mode, DISP_SETTING);
    kup <= 1'b0;
    @(posedge clk_i);
    tap(1'b0);
    chk(setp, 9'h12B);
    ce <= 1'b0;
    tap(1'b1);
    chk(setp, 9'h12B);
    ce <= 1'b1;
    sel <= 4'h0;
    wb(1'b1, 6'h04, 32'h50);
    sel <= 4'hF;
    chk(setp, 9'h12B);
    fault <= 9'h001;
    hold(80);
    chk(meas, 1'b0);
    chk(mode, DISP_ALARM);
    fault <= 9'h000;
    hold(35);
    hold(35);
    chk(meas, 1'b0);
    scon <= 1'b1;
    hold(80);
    chk(meas, 1'b0);
    chk(heat, 1'b1);
    wb(1'b1, 6'h04, 32'h28);
    @(posedge clk_i);
    chk(heat, 1'b0);
    wb(1'b1, 6'h04, 32'h29);
    @(posedge clk_i);
    chk(heat, 1'b1);
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, 6'h18, LIN[i]);
      @(posedge clk_i);
      chk(heat, LHE[i]);
    end
    scon <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(heat, 1'b0);
    cool <= 1'b1;
    kcal <= 1'b1;
    repeat (80) @(posedge clk_i);
    wb(1'b0, 6'h10, 32'h0);
    chk(rd, 32'h6B);
    // blink phase runs from reset, so wait for it either way
    repeat (6000) if (mode != DISP_CAL_STARS) @(posedge clk_i);
    chk(mode, DISP_CAL_STARS);
    chk(meas, 1'b0);
    repeat (6000) if (mode == DISP_CAL_STARS) @(posedge clk_i);
    chk(mode, DISP_HOME);
    kcal <= 1'b0;
    cool <= 1'b0;
    fault <= 9'h020;
    repeat (2) @(posedge clk_i);
    hold(80);
    chk(meas, 1'b0);
    fault <= 9'h001;
    hold(80);
    chk(meas, 1'b1);
    fault <= 9'h000;
    s24 <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(heat, 1'b0);
    chk(mode, DISP_CAL_COUNT);
    s24 <= 1'b0;
    repeat (450) @(posedge clk_i);
    chk(cnt, 4'h0);
    chk(meas, 1'b1);
    chk(act, 9'h019);
    wb(1'b1, 6'h00, 32'h2);
    repeat (2) @(posedge clk_i);
    chk(act, 9'h014);
    hold(80);
    repeat (450) @(posedge clk_i);
    wb(1'b1, 6'h00, 32'h4);
    repeat (2) @(posedge clk_i);
    chk(err, 9'h002);
    chk(mode, DISP_ALARM);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(setp, 9'h0C8);
    chk(mode, DISP_POWERUP);
    chk(err, 9'h000);
    conclude();
  end
endmodule : heatseal_calibration_start_control_bench
bind seal_ctrl seal_ctrl_chk #(.CLK_HZ(CLK_HZ), .KEY_HOLD_MS(KEY_HOLD_MS))
  chk_u (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i),
  .key_cal_i(key_cal_i), .heat_en_o(heat_en_o),
  .cal_measure_o(cal_measure_o), .disp_mode_o(disp_mode_o),
  .disp_count_o(disp_count_o), .disp_set_o(disp_set_o));
